/* File: rtl/dbs_pkg.sv */
// Shared constants for the bank, burst and self-refresh mode block
package dbs_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_MODE_ZERO = 8'h00;
    localparam logic [7:0] OFF_MODE_TWO = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;

    // Mode register zero field positions
    localparam int BF_LSB = 0;
    localparam int CL_LSB = 4;
    localparam int CWL_LSB = 8;
    localparam int AL_LSB = 12;

    // Mode register two bit positions
    localparam int ASR_BIT = 6;
    localparam int SRT_BIT = 7;

    // Status register field positions
    localparam int ST_SR_LSB = 8;
    localparam int ST_ERR_LSB = 16;

    // Reset values: on-the-fly burst, column latency 5, write latency 5
    localparam logic [31:0] MODE_ZERO_RST = 32'h0000_0551;
    localparam logic [1:0] MODE_TWO_RST = 2'h0;

    // Burst field encodings
    localparam logic [1:0] BURST_FIXED8 = 2'h0;
    localparam logic [1:0] BURST_OTF = 2'h1;

    // Additive latency selections
    localparam logic [1:0] AL_ZERO = 2'h0;
    localparam logic [1:0] AL_CL_M1 = 2'h1;
    localparam logic [1:0] AL_CL_M2 = 2'h2;

    // Self-refresh modes
    localparam logic [1:0] SR_NORMAL = 2'h0;
    localparam logic [1:0] SR_EXTENDED = 2'h1;
    localparam logic [1:0] SR_AUTO = 2'h2;

    // Command codes
    localparam logic [2:0] CMD_NOP = 3'h0;
    localparam logic [2:0] CMD_ACT = 3'h1;
    localparam logic [2:0] CMD_PRE = 3'h2;
    localparam logic [2:0] CMD_RD = 3'h3;
    localparam logic [2:0] CMD_WR = 3'h4;

    // Address bit positions with special meaning
    localparam int AP_BIT = 10;
    localparam int BSEL_BIT = 12;

    // Timing
    localparam int CLK_PERIOD_PS = 8000;
    localparam int TRP_PS = 15000;
    localparam logic [3:0] TRP_CYC =
        4'((TRP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [3:0] CCD_CYC = 4'h4;
    localparam logic [2:0] BC4_CYC = 3'h2;
    localparam logic [2:0] BL8_CYC = 3'h4;

endpackage

/* File: rtl/dbs_bank.sv */
// One bank: row open, precharge and auto precharge tracking
`timescale 1ns/1ps
`default_nettype none

module dbs_bank
    import dbs_pkg::*;
#(
    parameter int ROW_W = 15
)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Commands aimed at this bank
    input wire logic act,
    input wire logic pre,
    input wire logic acc,
    input wire logic ap,
    input wire logic [ROW_W-1:0] row_in,
    // Bank state
    output logic is_open,
    output logic ready,
    output logic [ROW_W-1:0] row
);

    typedef enum logic [1:0] {ST_IDLE, ST_OPEN, ST_PRE} dbs_bank_state_t;

    typedef struct packed {
        dbs_bank_state_t state;
        logic [3:0] cnt;
        logic [3:0] ap_cnt;
        logic opened;
        logic [ROW_W-1:0] row;
    } dbs_bank_st_t;

    dbs_bank_st_t st_ff;
    dbs_bank_st_t nxt_st;

    // Next state of the bank
    always_comb
    begin
        nxt_st = st_ff;
        case (st_ff.state)
            ST_IDLE:
            begin
                if (act)
                begin
                    nxt_st.state = ST_OPEN;
                    nxt_st.row = row_in;
                end
            end
            ST_OPEN:
            begin
                // Auto precharge starts one column spacing later
                if (acc && ap)
                    nxt_st.ap_cnt = CCD_CYC;
                else if (st_ff.ap_cnt == 4'h1)
                begin
                    nxt_st.ap_cnt = 4'h0;
                    nxt_st.state = ST_PRE;
                    nxt_st.cnt = TRP_CYC;
                end
                else if (st_ff.ap_cnt != 4'h0)
                    nxt_st.ap_cnt = st_ff.ap_cnt - 4'h1;
            end
            ST_PRE:
            begin
                if (st_ff.cnt == 4'h1)
                    nxt_st.state = ST_IDLE;
                nxt_st.cnt = st_ff.cnt - 4'h1;
            end
            default:
                nxt_st.state = ST_IDLE;
        endcase
        // Precharge wins in any state and restarts the period
        if (pre)
        begin
            nxt_st.state = ST_PRE;
            nxt_st.cnt = TRP_CYC;
            nxt_st.ap_cnt = 4'h0;
        end
        nxt_st.opened = (nxt_st.state == ST_OPEN);
    end

    // State register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st_ff <= '{state: ST_IDLE, default: '0};
        else
            st_ff <= nxt_st;
    end

    assign is_open = st_ff.opened;
    assign ready = (st_ff.state == ST_IDLE);
    assign row = st_ff.row;

endmodule

`default_nettype wire

/* File: rtl/dbs_core.sv */
// Command decode, burst control and mode registers behind APB
//
// Overview of operation
// - Both self-refresh bits low selects the normal-range refresh rate.
// - Temperature-range bit alone selects the extended-range refresh rate.
// - Auto management bit alone selects auto mode; both bits high illegal.
// - Activate opens the addressed row in the addressed bank.
// - An open row stays open until precharge reaches that bank.
// - Precharge closes one bank or all banks.
// - Bank may be activated only after the precharge period.
// - Precharged bank is idle; access needs an activate first.
// - Precharge to idle or precharging bank accepted, period restarts.
// - On-the-fly field: burst select low gives chopped four beats, high gives eight.
// - Burst select bit never forms part of the column address.
// - Either burst length works with or without auto precharge.
// - Setup or hold misses corrupt only the written location.
// - Strobe timing misses corrupt only that location, never hang.
// - Fixed-eight field, or on-the-fly with select high, gives eight beats.
`timescale 1ns/1ps
`default_nettype none

module dbs_core
    import dbs_pkg::*;
#(
    parameter int ROW_W = 15,
    parameter int DLY = 32
)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Command inputs
    input wire logic cmd_valid,
    input wire logic [2:0] cmd_code,
    input wire logic [2:0] cmd_bank,
    input wire logic [ROW_W-1:0] cmd_addr,
    input wire logic wr_strobe_err,
    // Command results
    output logic [7:0] bank_open,
    output logic cmd_refused,
    output logic burst_eight,
    output logic [9:0] burst_col,
    output logic [2:0] burst_bank,
    output logic burst_ap,
    // Data phase
    output logic rd_data_start,
    output logic wr_data_start,
    output logic wr_corrupt,
    // Self-refresh mode
    output logic [1:0] sr_mode
);

    typedef struct packed {
        logic [31:0] mode0;
        logic auto_refresh_management;
        logic self_refresh_temp_range;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [1:0] sr_mode;
        logic [DLY-1:0] rd_pipe;
        logic [DLY-1:0] wr_pipe;
        logic [DLY-1:0] b8_pipe;
        logic rd_start;
        logic wr_start;
        logic eight;
        logic [9:0] col;
        logic [2:0] bank;
        logic ap;
        logic [2:0] left;
        logic in_wr;
        logic bad;
        logic corrupt;
        logic refused;
        logic [7:0] err_cnt;
    } dbs_core_st_t;

    dbs_core_st_t st_ff;
    dbs_core_st_t nxt_st;

    logic [7:0] bank_ready;
    logic [7:0] pre_hit;
    logic [7:0] act_hit;
    logic [7:0] acc_hit;
    logic act_ok;
    logic col_cmd;
    logic col_ok;
    logic [5:0] rl;
    logic [5:0] wl;

    // Additive latency plus a base latency
    function automatic logic [5:0] add_lat(input logic [31:0] m0,
                                           input logic [3:0] base);
        logic [3:0] cl;
        logic [5:0] al;
        cl = m0[CL_LSB +: 4];
        case (m0[AL_LSB +: 2])
            AL_CL_M1: al = {2'h0, cl} - 6'h01;
            AL_CL_M2: al = {2'h0, cl} - 6'h02;
            default: al = 6'h00;
        endcase
        return al + {2'h0, base};
    endfunction

    // Eight-beat decision from burst field and burst select bit
    function automatic logic pick_eight(input logic [1:0] bf,
                                        input logic bsel);
        return (bf == BURST_FIXED8) || (bf == BURST_OTF && bsel);
    endfunction

    // Per-bank trackers
    for (genvar i = 0; i < 8; i++)
    begin : g_bank
        dbs_bank #(
            .ROW_W(ROW_W)
        ) u_bank (
            .pclk(pclk),
            .presetn(presetn),
            .act(act_hit[i]),
            .pre(pre_hit[i]),
            .acc(acc_hit[i]),
            .ap(cmd_addr[AP_BIT]),
            .row_in(cmd_addr),
            .is_open(bank_open[i]),
            .ready(bank_ready[i]),
            .row()
        );
    end

    // Command qualification
    always_comb
    begin
        act_ok = cmd_valid && cmd_code == CMD_ACT
                 && bank_ready[cmd_bank];
        col_cmd = cmd_valid && (cmd_code == CMD_RD || cmd_code == CMD_WR);
        col_ok = col_cmd && bank_open[cmd_bank];
        rl = add_lat(st_ff.mode0, st_ff.mode0[CL_LSB +: 4]);
        wl = add_lat(st_ff.mode0, st_ff.mode0[CWL_LSB +: 4]);
        for (int i = 0; i < 8; i++)
        begin
            pre_hit[i] = cmd_valid && cmd_code == CMD_PRE
                         && (cmd_addr[AP_BIT] || cmd_bank == 3'(i));
            act_hit[i] = act_ok && cmd_bank == 3'(i);
            acc_hit[i] = col_ok && cmd_bank == 3'(i);
        end
    end

    // Next state of registers, latency pipes and burst tracking
    always_comb
    begin
        logic [4:0] idx;
        idx = 5'h0;
        nxt_st = st_ff;
        // APB: answer registered for the access phase
        nxt_st.pready = psel && !penable;
        nxt_st.prdata = 32'h0000_0000;
        nxt_st.pslverr = 1'b0;
        if (psel && !penable)
        begin
            case (paddr)
                OFF_MODE_ZERO:
                    nxt_st.prdata = st_ff.mode0;
                OFF_MODE_TWO:
                begin
                    nxt_st.prdata[ASR_BIT] = st_ff.auto_refresh_management;
                    nxt_st.prdata[SRT_BIT] = st_ff.self_refresh_temp_range;
                    nxt_st.pslverr = pwrite && pwdata[ASR_BIT]
                                     && pwdata[SRT_BIT];
                end
                OFF_STATUS:
                begin
                    nxt_st.prdata[7:0] = bank_open;
                    nxt_st.prdata[ST_SR_LSB +: 2] = st_ff.sr_mode;
                    nxt_st.prdata[ST_ERR_LSB +: 8] = st_ff.err_cnt;
                    nxt_st.pslverr = pwrite;
                end
                default:
                    nxt_st.pslverr = 1'b1;
            endcase
        end
        // Writes land at the edge that completes the access
        if (psel && penable && st_ff.pready && pwrite && !st_ff.pslverr)
        begin
            case (paddr)
                OFF_MODE_ZERO:
                    nxt_st.mode0 = pwdata;
                OFF_MODE_TWO:
                begin
                    nxt_st.auto_refresh_management = pwdata[ASR_BIT];
                    nxt_st.self_refresh_temp_range = pwdata[SRT_BIT];
                end
                default:
                    nxt_st.mode0 = st_ff.mode0;
            endcase
        end
        // Self-refresh mode decode
        case ({st_ff.auto_refresh_management, st_ff.self_refresh_temp_range})
            2'b01: nxt_st.sr_mode = SR_EXTENDED;
            2'b10: nxt_st.sr_mode = SR_AUTO;
            default: nxt_st.sr_mode = SR_NORMAL;
        endcase
        // Latency pipes shift toward bit zero
        nxt_st.rd_pipe = st_ff.rd_pipe >> 1;
        nxt_st.wr_pipe = st_ff.wr_pipe >> 1;
        nxt_st.b8_pipe = st_ff.b8_pipe >> 1;
        nxt_st.rd_start = st_ff.rd_pipe[0];
        nxt_st.wr_start = st_ff.wr_pipe[0];
        nxt_st.refused = (cmd_valid && cmd_code == CMD_ACT && !act_ok)
                         || (col_cmd && !col_ok);
        if (col_ok)
        begin
            // Select bit only picks length, never addresses
            nxt_st.eight = pick_eight(st_ff.mode0[BF_LSB +: 2],
                                      cmd_addr[BSEL_BIT]);
            nxt_st.col = cmd_addr[9:0];
            nxt_st.bank = cmd_bank;
            nxt_st.ap = cmd_addr[AP_BIT];
            if (cmd_code == CMD_RD)
            begin
                idx = 5'(rl - 6'h02);
                nxt_st.rd_pipe[idx] = 1'b1;
            end
            else
            begin
                idx = 5'(wl - 6'h02);
                nxt_st.wr_pipe[idx] = 1'b1;
            end
            nxt_st.b8_pipe[idx] = nxt_st.eight;
        end
        // Data burst: a bad strobe only marks this write
        nxt_st.corrupt = 1'b0;
        if (st_ff.left != 3'h0)
        begin
            nxt_st.left = st_ff.left - 3'h1;
            nxt_st.bad = st_ff.bad || (st_ff.in_wr && wr_strobe_err);
            if (st_ff.left == 3'h1 && st_ff.in_wr && nxt_st.bad)
            begin
                nxt_st.corrupt = 1'b1;
                nxt_st.err_cnt = st_ff.err_cnt + 8'h01;
            end
        end
        if (st_ff.rd_pipe[0] || st_ff.wr_pipe[0])
        begin
            nxt_st.left = st_ff.b8_pipe[0] ? BL8_CYC : BC4_CYC;
            nxt_st.in_wr = st_ff.wr_pipe[0];
            nxt_st.bad = 1'b0;
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st_ff <= '{mode0: MODE_ZERO_RST, auto_refresh_management: MODE_TWO_RST[1],
                       self_refresh_temp_range: MODE_TWO_RST[0], default: '0};
        else
            st_ff <= nxt_st;
    end

    // Outputs straight from the state register
    assign prdata = st_ff.prdata;
    assign pready = st_ff.pready;
    assign pslverr = st_ff.pslverr;
    assign cmd_refused = st_ff.refused;
    assign burst_eight = st_ff.eight;
    assign burst_col = st_ff.col;
    assign burst_bank = st_ff.bank;
    assign burst_ap = st_ff.ap;
    assign rd_data_start = st_ff.rd_start;
    assign wr_data_start = st_ff.wr_start;
    assign wr_corrupt = st_ff.corrupt;
    assign sr_mode = st_ff.sr_mode;

    // Checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_sr_normal;
        {st_ff.auto_refresh_management, st_ff.self_refresh_temp_range} == 2'b00 |=> sr_mode == SR_NORMAL;
    endproperty
    a_sr_normal: assert property (p_sr_normal)
        else $error("normal self-refresh mode not selected");

    property p_sr_ext;
        {st_ff.auto_refresh_management, st_ff.self_refresh_temp_range} == 2'b01 |=> sr_mode == SR_EXTENDED;
    endproperty
    a_sr_ext: assert property (p_sr_ext)
        else $error("extended self-refresh mode not selected");

    property p_sr_illegal;
        !(st_ff.auto_refresh_management && st_ff.self_refresh_temp_range) && sr_mode != 2'h3;
    endproperty
    a_sr_illegal: assert property (p_sr_illegal)
        else $error("illegal self-refresh setting stored");

    property p_act_opens;
        act_ok |=> bank_open[$past(cmd_bank)];
    endproperty
    a_act_opens: assert property (p_act_opens)
        else $error("activate did not open the bank");

    property p_pre_closes;
        pre_hit[0] |=> !bank_open[0];
    endproperty
    a_pre_closes: assert property (p_pre_closes)
        else $error("precharge left bank zero open");

    sequence s_pre_wait;
        !bank_ready[0] [*2];
    endsequence
    property p_trp;
        pre_hit[0] |=> s_pre_wait;
    endproperty
    a_trp: assert property (p_trp)
        else $error("bank ready before precharge period");

    property p_chop;
        col_ok && st_ff.mode0[BF_LSB +: 2] == BURST_OTF
        && !cmd_addr[BSEL_BIT] |=> !burst_eight;
    endproperty
    a_chop: assert property (p_chop)
        else $error("chopped burst not selected");

    property p_col;
        col_ok |=> burst_col == $past(cmd_addr[9:0]);
    endproperty
    a_col: assert property (p_col)
        else $error("column address wrong");

    property p_fixed8;
        col_ok && st_ff.mode0[BF_LSB +: 2] == BURST_FIXED8 |=> burst_eight;
    endproperty
    a_fixed8: assert property (p_fixed8)
        else $error("fixed eight-beat burst not selected");

    property p_rl5;
        col_ok && cmd_code == CMD_RD && rl == 6'h05 |-> ##5 rd_data_start;
    endproperty
    a_rl5: assert property (p_rl5)
        else $error("read data start not at latency");

    property p_corrupt;
        wr_corrupt |-> $past(st_ff.in_wr) && $past(st_ff.left) == 3'h1;
    endproperty
    a_corrupt: assert property (p_corrupt)
        else $error("corrupt mark outside write burst end");

endmodule

`default_nettype wire

/* File: tb/dbs_ctrl_model.sv */
// Memory controller model driving the command port
`timescale 1ns/1ps
`default_nettype none

module dbs_ctrl_model
    import dbs_pkg::*;
#(
    parameter int ROW_W = 15
)
(
    // Clock
    input wire logic pclk,
    // Command outputs
    output logic cmd_valid,
    output logic [2:0] cmd_code,
    output logic [2:0] cmd_bank,
    output logic [ROW_W-1:0] cmd_addr,
    output logic wr_strobe_err
);
    // Quiet bus at time zero
    initial
    begin
        cmd_valid = 1'b0;
        cmd_code = CMD_NOP;
        cmd_bank = 3'h0;
        cmd_addr = '0;
        wr_strobe_err = 1'b0;
    end

    // One command for one cycle, then the bus is let go
    task automatic issue(input logic [2:0] c, input logic [2:0] b,
                         input logic [ROW_W-1:0] a);
        @(posedge pclk);
        cmd_valid <= 1'b1;
        cmd_code <= c;
        cmd_bank <= b;
        cmd_addr <= a;
        @(posedge pclk);
        cmd_valid <= 1'b0;
        cmd_bank <= ~b; // Bank and address lines keep no stale value
        cmd_addr <= ~a;
    endtask

    // Strobe timing kept clean unless a scenario breaks it
    task automatic strobe(input logic bad);
        @(posedge pclk);
        wr_strobe_err <= bad;
    endtask
endmodule

`default_nettype wire

/* File: tb/tb_dbs_core.sv */
// Self-checking bench for the bank, burst and self-refresh block
`timescale 1ns/1ps
`default_nettype none

module tb_dbs_core
    import dbs_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, cmd_valid, wr_strobe_err;
    wire logic [2:0] cmd_code, cmd_bank, burst_bank;
    wire logic [14:0] cmd_addr;
    wire logic [7:0] bank_open;
    wire logic cmd_refused, burst_eight, burst_ap;
    wire logic [9:0] burst_col;
    wire logic rd_data_start, wr_data_start, wr_corrupt;
    wire logic [1:0] sr_mode;
    int fails = 0;
    int num_checks = 0;
    logic [31:0] q;
    logic e;
    int n;

    dbs_core DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_bank(cmd_bank),
        .cmd_addr(cmd_addr), .wr_strobe_err(wr_strobe_err),
        .bank_open(bank_open), .cmd_refused(cmd_refused),
        .burst_eight(burst_eight), .burst_col(burst_col),
        .burst_bank(burst_bank), .burst_ap(burst_ap),
        .rd_data_start(rd_data_start), .wr_data_start(wr_data_start),
        .wr_corrupt(wr_corrupt), .sr_mode(sr_mode));

    dbs_ctrl_model u_ctrl (.pclk(pclk), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .cmd_bank(cmd_bank), .cmd_addr(cmd_addr),
        .wr_strobe_err(wr_strobe_err));

    // 125 MHz clock
    initial
    begin
        forever #4 pclk = ~pclk;
    end

    // Compare and count
    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        num_checks++;
        if (s !== x)
        begin
            fails++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, x);
        end
    endtask

    // Verdict and end of run
    task automatic results;
        $display("checks=%0d mismatches=%0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // One APB transfer, held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 50);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 50)
            chk(32'h0, 32'h1);
    endtask

    // Command, then settle into the answer cycle
    task automatic cmd(input logic [2:0] c, input logic [2:0] b,
                       input logic [14:0] a);
        u_ctrl.issue(c, b, a);
        #1;
    endtask

    // Cycles until a data-phase pulse shows
    task automatic wait_pulse(input int sel, output int k);
        logic s;
        k = 0;
        s = 1'b0;
        while (s !== 1'b1 && k < 30)
        begin
            s = sel == 0 ? rd_data_start :
                sel == 1 ? wr_data_start : wr_corrupt;
            if (s !== 1'b1)
            begin
                @(posedge pclk);
                #1;
                k++;
            end
        end
    endtask

    // Reset values, unmapped and read-only places
    task automatic t_regs;
        apb(1'b0, OFF_MODE_ZERO, 32'h0);
        chk(q, MODE_ZERO_RST);
        apb(1'b0, OFF_MODE_TWO, 32'h0);
        chk(q, 32'h0);
        apb(1'b0, 8'h0C, 32'h0);
        chk(e, 1'b1);
        apb(1'b1, OFF_STATUS, 32'hFF);
        chk(e, 1'b1);
    endtask

    // Every self-refresh setting, then the illegal pair
    task automatic t_sr;
        logic [31:0] wv[4];
        logic [1:0] mv[4];
        wv = '{32'h1 << SRT_BIT, 32'h1 << ASR_BIT, 32'h0,
               (32'h1 << ASR_BIT) | (32'h1 << SRT_BIT)};
        mv = '{SR_EXTENDED, SR_AUTO, SR_NORMAL, SR_NORMAL};
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b1, OFF_MODE_TWO, wv[i]);
            chk(e, i == 3);
            repeat (2) @(posedge pclk);
            #1;
            chk(sr_mode, mv[i]);
        end
    endtask

    // Open, refuse, precharge, restart of the precharge period
    task automatic t_bank;
        cmd(CMD_ACT, 3'h3, 15'h5A5A);
        chk(bank_open, 8'h08);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk(q[7:0], 8'h08);
        cmd(CMD_RD, 3'h3, 15'h0010);
        chk(cmd_refused, 1'b0);
        cmd(CMD_ACT, 3'h3, 15'h1234);
        chk({cmd_refused, bank_open}, 9'h108);
        cmd(CMD_PRE, 3'h3, 15'h0);
        chk(bank_open, 8'h00);
        cmd(CMD_PRE, 3'h3, 15'h0);
        chk(cmd_refused, 1'b0);
        cmd(CMD_ACT, 3'h3, 15'h1234);
        chk(cmd_refused, 1'b1);
        cmd(CMD_RD, 3'h3, 15'h0);
        chk(cmd_refused, 1'b1);
        cmd(CMD_ACT, 3'h3, 15'h1234);
        cmd(CMD_ACT, 3'h5, 15'h0001);
        chk(bank_open, 8'h28);
        cmd(CMD_PRE, 3'h0, 15'h1 << AP_BIT);
        chk(bank_open, 8'h00);
    endtask

    // Burst length, column and auto precharge per command
    task automatic t_burst;
        logic [14:0] a;
        logic [9:0] col;
        for (int i = 0; i < 4; i++)
        begin
            repeat (4) @(posedge pclk);
            cmd(CMD_ACT, 3'h1, 15'h0777);
            col = 10'h3A5 ^ 10'(i);
            a = {2'b00, 1'(i & 1), 1'b0, 1'(i >> 1), col};
            cmd(i[0] ? CMD_WR : CMD_RD, 3'h1, a);
            chk({burst_eight, burst_bank}, {i[0], 3'h1});
            chk(burst_ap, i[1]);
            chk(burst_col, col);
            wait_pulse(i & 1, n);
            chk(n, 4);
            repeat (12) @(posedge pclk);
            #1;
            chk(bank_open[1], !i[1]);
            if (!i[1])
                cmd(CMD_PRE, 3'h1, 15'h0);
        end
    endtask

    // Latency with additive part, fixed field modes
    task automatic t_mode;
        apb(1'b1, OFF_MODE_ZERO, 32'h1551);
        cmd(CMD_ACT, 3'h2, 15'h0);
        cmd(CMD_RD, 3'h2, 15'h0);
        wait_pulse(0, n);
        chk(n, 8);
        cmd(CMD_WR, 3'h2, 15'h0);
        wait_pulse(1, n);
        chk(n, 8);
        apb(1'b1, OFF_MODE_ZERO, 32'h0550);
        cmd(CMD_WR, 3'h2, 15'h0);
        chk(burst_eight, 1'b1);
        apb(1'b1, OFF_MODE_ZERO, 32'h0552);
        cmd(CMD_WR, 3'h2, 15'h1 << BSEL_BIT);
        chk(burst_eight, 1'b0);
        apb(1'b1, OFF_MODE_ZERO, MODE_ZERO_RST);
        cmd(CMD_WR, 3'h2, 15'h1 << BSEL_BIT);
        chk(burst_eight, 1'b1);
    endtask

    // Access to another bank during auto precharge
    task automatic t_ap;
        repeat (8) @(posedge pclk);
        cmd(CMD_ACT, 3'h6, 15'h0);
        cmd(CMD_RD, 3'h2, 15'h1 << AP_BIT);
        cmd(CMD_RD, 3'h6, 15'h0);
        chk(cmd_refused, 1'b0);
        repeat (12) @(posedge pclk);
        #1;
        chk(bank_open, 8'h40);
    endtask

    // Strobe fault during a write burst
    task automatic t_err;
        u_ctrl.strobe(1'b1);
        cmd(CMD_WR, 3'h6, 15'h1 << BSEL_BIT);
        wait_pulse(2, n);
        chk(n, 8);
        u_ctrl.strobe(1'b0);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk(q[23:16], 8'h01);
        cmd(CMD_RD, 3'h6, 15'h0);
        chk(cmd_refused, 1'b0);
    endtask

    // Watchdog
    initial
    begin
        #100000;
        fails++;
        results;
    end

    // Main sequence
    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_sr;
        t_bank;
        t_burst;
        t_mode;
        t_ap;
        t_err;
        results;
    end
endmodule

`default_nettype wire
